// ===== hw/tdec_counters.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// - Keep a 12-bit transmit-frame counter in bits 11 to 0.
// - Add one to the frame counter each time a frame-sent event is reported.
// - Keep a 12-bit late-delay warning counter, one per warning report.
// - That warning is the one raised for a too-late delayed send or receive.
// - Keep a 12-bit transmitter power-up warning counter, one per error report.
// - That error is raised when delayed send leaves too little power-up time.
// - No counter advances while the global enable bit is clear; counts hold.
// - Bits 15 to 12 of each counter register are reserved and read zero.
module tdec_counters (
  // Clock, reset, clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire tdec_pkg::tdec_ahb_req_type ahb_req,
  input wire logic [tdec_pkg::TDEC_DATA_WIDTH-1:0] hwdata,
  output logic [tdec_pkg::TDEC_DATA_WIDTH-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event sources and enable state
  input wire tdec_pkg::tdec_events_type events,
  output logic event_count_enable
);
  import tdec_pkg::*;

  typedef struct packed {
    logic enable;
    logic pend_write;
    tdec_sel_type pend_sel;
    logic [TDEC_DATA_WIDTH-1:0] rdata;
    logic readyout;
    logic resp;
  } tdec_state_type;

  tdec_state_type state_q;
  tdec_state_type state_d;
  logic [TDEC_CNT_WIDTH-1:0] count [TDEC_NUM_CNT];
  logic [TDEC_NUM_CNT-1:0] event_vec;
  logic take;
  logic enable_now;

  // Word-aligned decode, shared by the read and the write paths
  function automatic tdec_sel_type tdec_decode(input logic [TDEC_ADDR_WIDTH-1:0] addr);
    tdec_sel_type sel;
    sel = TDEC_SEL_NONE;
    if (addr[TDEC_ADDR_WIDTH-1:10] == '0 && addr[1:0] == 2'b00)
    begin
      case (addr[9:2])
        TDEC_IDX_CONTROL: sel = TDEC_SEL_CONTROL;
        TDEC_IDX_TX_FRAME_SENT: sel = TDEC_SEL_TX_FRAME_SENT;
        TDEC_IDX_HALF_PERIOD_WARNING: sel = TDEC_SEL_HALF_PERIOD;
        TDEC_IDX_TX_POWERUP_WARNING: sel = TDEC_SEL_TX_POWERUP;
        default: sel = TDEC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : tdec_decode

  // Counter value placed in a 32-bit word, upper bits zero
  function automatic logic [TDEC_DATA_WIDTH-1:0] tdec_word(input logic [TDEC_CNT_WIDTH-1:0] c);
    return {{(TDEC_DATA_WIDTH-TDEC_CNT_WIDTH){1'b0}}, c};
  endfunction : tdec_word

  // Event slots: frame sent, late delay warning, power-up time error
  assign event_vec[TDEC_SLOT_FRAME_SENT] = events.frame_sent_event;
  assign event_vec[TDEC_SLOT_LATE_DELAY] = events.late_delay_warning_event;
  assign event_vec[TDEC_SLOT_POWERUP] = events.powerup_time_error_event;

  // Enable as software sees it, including a write now in its data phase
  assign enable_now = (state_q.pend_write && state_q.pend_sel == TDEC_SEL_CONTROL) ?
                      hwdata[TDEC_ENABLE_BIT] : state_q.enable;

  // One identical counter per event source
  genvar gi;
  generate
    for (gi = 0; gi < TDEC_NUM_CNT; gi++)
    begin : g_cnt
      tdec_event_counter #(
        .WIDTH(TDEC_CNT_WIDTH)
      ) u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .count_enable(state_q.enable),
        .event_level(event_vec[gi]),
        .count(count[gi])
      );
    end
  endgenerate

  // Address phase accepted: selected, valid transfer, bus ready
  assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

  // Zero wait state slave; read word is registered at the address phase
  always_comb
  begin
    state_d = state_q;
    state_d.readyout = 1'b1;
    state_d.resp = 1'b0;
    state_d.pend_write = 1'b0;
    state_d.pend_sel = TDEC_SEL_NONE;
    // Write data phase: only the control bit is writable
    if (state_q.pend_write && state_q.pend_sel == TDEC_SEL_CONTROL)
    begin
      state_d.enable = hwdata[TDEC_ENABLE_BIT];
    end
    if (take)
    begin
      state_d.pend_write = ahb_req.hwrite;
      state_d.pend_sel = tdec_decode(ahb_req.haddr);
      if (!ahb_req.hwrite)
      begin
        // Writes to counter words fall through unstored
        case (tdec_decode(ahb_req.haddr))
          TDEC_SEL_CONTROL: state_d.rdata = {{(TDEC_DATA_WIDTH-1){1'b0}}, enable_now};
          TDEC_SEL_TX_FRAME_SENT: state_d.rdata = tdec_word(count[TDEC_SLOT_FRAME_SENT]);
          TDEC_SEL_HALF_PERIOD: state_d.rdata = tdec_word(count[TDEC_SLOT_LATE_DELAY]);
          TDEC_SEL_TX_POWERUP: state_d.rdata = tdec_word(count[TDEC_SLOT_POWERUP]);
          default: state_d.rdata = TDEC_RDATA_RESET;
        endcase
      end
    end
  end

  // Single state register; clock enable low freezes bus and control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q.enable <= TDEC_ENABLE_RESET;
      state_q.pend_write <= 1'b0;
      state_q.pend_sel <= TDEC_SEL_NONE;
      state_q.rdata <= TDEC_RDATA_RESET;
      state_q.readyout <= 1'b1;
      state_q.resp <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops; response is always OKAY
  assign hrdata = state_q.rdata;
  assign hreadyout = state_q.readyout;
  assign hresp = state_q.resp;
  assign event_count_enable = state_q.enable;

endmodule : tdec_counters

// ===== hw/tdec_pkg.sv
package tdec_pkg;

  // Counter geometry
  localparam int TDEC_CNT_WIDTH = 12;
  localparam int TDEC_NUM_CNT = 3;
  localparam int TDEC_REG_WIDTH = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] TDEC_IDX_CONTROL = 8'h00;
  localparam logic [7:0] TDEC_IDX_TX_FRAME_SENT = 8'h16;
  localparam logic [7:0] TDEC_IDX_HALF_PERIOD_WARNING = 8'h18;
  localparam logic [7:0] TDEC_IDX_TX_POWERUP_WARNING = 8'h1a;

  // Bus geometry
  localparam int TDEC_ADDR_WIDTH = 32;
  localparam int TDEC_DATA_WIDTH = 32;

  // Control register fields and reset values
  localparam int TDEC_ENABLE_BIT = 0;
  localparam logic TDEC_ENABLE_RESET = 1'b0;
  localparam logic [TDEC_CNT_WIDTH-1:0] TDEC_CNT_RESET = 12'h000;
  localparam logic [TDEC_DATA_WIDTH-1:0] TDEC_RDATA_RESET = 32'h0000_0000;

  // Counter slot of each event source
  localparam int TDEC_SLOT_FRAME_SENT = 0;
  localparam int TDEC_SLOT_LATE_DELAY = 1;
  localparam int TDEC_SLOT_POWERUP = 2;

  // Event sources from the sequencing logic, one level each
  typedef struct packed {
    logic powerup_time_error_event;
    logic late_delay_warning_event;
    logic frame_sent_event;
  } tdec_events_type;

  // Register selected by an address
  typedef enum logic [2:0] {
    TDEC_SEL_NONE = 3'b000,
    TDEC_SEL_CONTROL = 3'b001,
    TDEC_SEL_TX_FRAME_SENT = 3'b010,
    TDEC_SEL_HALF_PERIOD = 3'b011,
    TDEC_SEL_TX_POWERUP = 3'b100
  } tdec_sel_type;

  // Address phase of an AHB-Lite transfer
  typedef struct packed {
    logic hsel;
    logic [TDEC_ADDR_WIDTH-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } tdec_ahb_req_type;

endpackage : tdec_pkg

// ===== hw/tdec_event_counter.sv
`timescale 1ns/100ps
module tdec_event_counter #(
  parameter int WIDTH = tdec_pkg::TDEC_CNT_WIDTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control and event
  input wire logic count_enable,
  input wire logic event_level,
  // Count value
  output logic [WIDTH-1:0] count
);
  import tdec_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic prev;
  } tdec_cnt_state_type;

  tdec_cnt_state_type state_q;
  tdec_cnt_state_type state_d;

  // One count per rising edge, so a level held high is one report
  always_comb
  begin
    state_d = state_q;
    state_d.prev = event_level;
    if (count_enable && event_level && !state_q.prev)
    begin
      state_d.count = WIDTH'(state_q.count + 1'b1);
    end
  end

  // Clock enable freezes the count and the edge history together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q.count <= '0;
      state_q.prev <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
    end
  end

  assign count = state_q.count;

endmodule : tdec_event_counter

// ===== tb/tdec_counters_chk.sv
`timescale 1ns/100ps
module tdec_counters_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire tdec_pkg::tdec_ahb_req_type ahb_req,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Events and enable
  input wire tdec_pkg::tdec_events_type events,
  input wire logic event_count_enable
);
  import tdec_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd;
  logic wr_ctrl_q;
  // Accepted address phase
  assign take = ce && ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  assign rd = take && !ahb_req.hwrite;
  // Control write in its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_ctrl_q <= 1'b0;
    else if (ce)
      wr_ctrl_q <= take && ahb_req.hwrite && ahb_req.haddr == 32'h0000_0000;
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_READY: assert property (hreadyout)
    else $error("wait state seen");
  AST_UPPER: assert property (hrdata[31:12] == 20'h0_0000)
    else $error("upper read bits set");
  AST_EN_WR: assert property (wr_ctrl_q && ce |=> event_count_enable == $past(hwdata[0]))
    else $error("enable not written");
  AST_EN_HOLD: assert property (!wr_ctrl_q |=> $stable(event_count_enable))
    else $error("enable moved");
  AST_RD_CTRL: assert property (rd && ahb_req.haddr == 32'h0 |=> hrdata[0] == event_count_enable)
    else $error("control readback wrong");
  AST_RD_VOID: assert property (rd && ahb_req.haddr[1:0] != 2'b00 |=> hrdata == 32'h0)
    else $error("misaligned read not zero");
  AST_RD_HOLD: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  // Main scenarios
  cover property (wr_ctrl_q);
  cover property (rd && ahb_req.haddr == 32'h0000_0058);
  cover property (event_count_enable && $rose(events.frame_sent_event));
endmodule : tdec_counters_chk

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tdec_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  tdec_ahb_req_type req = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rdat;
  logic hreadyout;
  logic hresp;
  logic event_count_enable;
  tdec_events_type ev = '0;
  int err_count = 0;
  int total_checks = 0;
  // Rows: enable, event mask, then frame, late, power-up counts
  logic [39:0] rows [4] = '{{1'b1, 3'b001, 36'h001_000_000}, {1'b1, 3'b110, 36'h001_001_001},
    {1'b0, 3'b111, 36'h001_001_001}, {1'b1, 3'b111, 36'h002_002_002}};
  // Clock
  always #20 hclk = ~hclk;
  tdec_counters dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .ahb_req({req[$bits(req)-1:1], hreadyout}), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(ev), .event_count_enable(event_count_enable));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Single transfer; waits on hready, so slow slaves work too
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    req <= '{1'b1, a, 2'b10, wr, 3'b010, 1'b0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    req <= '0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask : rd_chk
  // One low cycle between reports, else they merge
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      ev <= m;
      @(posedge hclk);
      ev <= '0;
    end
  endtask : pulse
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h0000_0058, 32'h0000_0000);
    foreach (rows[i])
    begin
      bus(1'b1, 32'h0000_0000, {31'h0, rows[i][39]});
      rd_chk(32'h0000_0000, {31'h0, rows[i][39]});
      check({31'h0, event_count_enable}, {31'h0, rows[i][39]});
      pulse(rows[i][38:36], 1);
      for (int k = 0; k < 3; k++)
        rd_chk(32'h58 + 8 * k, {20'h0, rows[i][35 - 12 * k -: 12]});
      $display("row %0d done", i);
    end
    // Level held high is one report; writes to a count are dropped
    @(posedge hclk);
    ev <= 3'b001;
    repeat (5) @(posedge hclk);
    ev <= '0;
    bus(1'b1, 32'h0000_0058, 32'hffff_ffff);
    rd_chk(32'h0000_0058, 32'h0000_0003);
    pulse(3'b001, 4092);
    rd_chk(32'h0000_0058, 32'h0000_0fff);
    pulse(3'b001, 1);
    rd_chk(32'h0000_0058, 32'h0000_0000);
    rd_chk(32'h0000_0059, 32'h0000_0000);
    // Clock enable low freezes the count and its edge history
    @(posedge hclk);
    ce <= 1'b0;
    pulse(3'b001, 1);
    @(posedge hclk);
    ce <= 1'b1;
    rd_chk(32'h0000_0058, 32'h0000_0000);
    // Second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h0000_0060, 32'h0000_0000);
    rd_chk(32'h0000_0000, 32'h0000_0000);
    check({31'h0, event_count_enable}, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    $display("hand tests done");
    give_verdict();
  end
  // Watchdog, well past the expected run
  initial
  begin
    #(40 * 12000);
    err_count++;
    give_verdict();
  end
endmodule : testbench
bind tdec_counters tdec_counters_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .ahb_req(ahb_req), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .events(events), .event_count_enable(event_count_enable));
